// *** logic/led_pair_pkg.sv ***
// Constants, register map and state types shared by the LED pair current controller.
package led_pair_pkg;

   // ==========================================================================
   // Serial bus identity and register map
   localparam logic [6:0] BUS_ADDRESS       = 7'h66;
   localparam logic [1:0] PAIR_A_OFFSET     = 2'h0;
   localparam logic [1:0] PAIR_B_OFFSET     = 2'h1;
   localparam logic [1:0] PAIR_C_OFFSET     = 2'h2;
   localparam logic [1:0] ON_OFF_OFFSET     = 2'h3;
   localparam logic [5:0] REG_RESET         = 6'h00;

   // ==========================================================================
   // Field positions
   localparam int CODE_MSB                  = 5;
   localparam int CH_A_FIRST_BIT            = 0;
   localparam int CH_A_SECOND_BIT           = 1;
   localparam int CH_B_FIRST_BIT            = 2;
   localparam int CH_B_SECOND_BIT           = 3;
   localparam int CH_C_FIRST_BIT            = 4;
   localparam int CH_C_SECOND_BIT           = 5;

   // ==========================================================================
   // Timing
   localparam int CLOCK_PERIOD_NS           = 8;
   localparam int MODE_DELAY_US             = 400;
   localparam int MODE_DELAY_CYCLES         = (MODE_DELAY_US * 1000) / CLOCK_PERIOD_NS;

   // ==========================================================================
   // State types
   typedef enum logic [1:0] {
      MODE_1X   = 2'b00,
      MODE_WAIT = 2'b01,
      MODE_1P5  = 2'b10
   } pump_mode_t;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_DEVADDR = 3'b001,
      ST_REGADDR = 3'b010,
      ST_WDATA   = 3'b011,
      ST_ACK     = 3'b100,
      ST_RDATA   = 3'b101,
      ST_RACK    = 3'b110
   } bus_state_t;

endpackage

// *** logic/serial_register_port.sv ***
// Two-wire serial target that turns bus transfers into register writes and reads.
`timescale 1ns/1ps

module serial_register_port (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       clear,
   // Bus pins
   input  wire logic       scl,
   input  wire logic       sda,
   output logic            sda_oe_n,
   // Register side
   input  wire logic [7:0] rd_data,
   output logic [1:0]      reg_index,
   output logic            wr_stb,
   output logic [1:0]      wr_addr,
   output logic [7:0]      wr_data
);

   logic                    scl_q;
   logic                    sda_q;
   logic [7:0]              shift;
   logic [3:0]              cnt;
   led_pair_pkg::bus_state_t state;
   led_pair_pkg::bus_state_t after;

   wire start_seen = scl & scl_q & sda_q & ~sda;
   wire stop_seen  = scl & scl_q & ~sda_q & sda;
   wire scl_rise   = scl & ~scl_q;
   wire scl_fall   = ~scl & scl_q;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // ==========================================================================
   // Transfer sequencer
   // Our own data only changes while the clock is low, so it never looks like a start or stop.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state     <= led_pair_pkg::ST_IDLE;
         after     <= led_pair_pkg::ST_IDLE;
         shift     <= 8'h00;
         cnt       <= 4'h0;
         sda_oe_n  <= 1'b1;
         reg_index <= 2'h0;
         wr_stb    <= 1'b0;
         wr_addr   <= 2'h0;
         wr_data   <= 8'h00;
      end else begin
         wr_stb <= 1'b0;
         if (clear || stop_seen) begin
            state    <= led_pair_pkg::ST_IDLE;
            sda_oe_n <= 1'b1;
         end else if (start_seen) begin
            state    <= led_pair_pkg::ST_DEVADDR;
            cnt      <= 4'h0;
            sda_oe_n <= 1'b1;
         end else begin
            unique case (state)
               led_pair_pkg::ST_IDLE: begin
               end
               led_pair_pkg::ST_DEVADDR, led_pair_pkg::ST_REGADDR, led_pair_pkg::ST_WDATA: begin
                  if (scl_rise) begin
                     shift <= {shift[6:0], sda};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && cnt == 4'h8) begin
                     state    <= led_pair_pkg::ST_ACK;
                     sda_oe_n <= 1'b0;
                     if (state == led_pair_pkg::ST_DEVADDR) begin
                        if (shift[7:1] == led_pair_pkg::BUS_ADDRESS) begin
                           after <= shift[0] ? led_pair_pkg::ST_RDATA : led_pair_pkg::ST_REGADDR;
                        end else begin
                           state    <= led_pair_pkg::ST_IDLE;
                           sda_oe_n <= 1'b1;
                        end
                     end else if (state == led_pair_pkg::ST_REGADDR) begin
                        reg_index <= shift[1:0];
                        after     <= led_pair_pkg::ST_WDATA;
                     end else begin
                        wr_stb    <= 1'b1;
                        wr_addr   <= reg_index;
                        wr_data   <= shift;
                        reg_index <= reg_index + 2'h1;
                        after     <= led_pair_pkg::ST_WDATA;
                     end
                  end
               end
               led_pair_pkg::ST_ACK: begin
                  if (scl_fall) begin
                     state <= after;
                     cnt   <= 4'h0;
                     if (after == led_pair_pkg::ST_RDATA) begin
                        shift    <= rd_data;
                        sda_oe_n <= rd_data[7];
                     end else begin
                        sda_oe_n <= 1'b1;
                     end
                  end
               end
               led_pair_pkg::ST_RDATA: begin
                  if (scl_rise) begin
                     cnt <= cnt + 4'h1;
                  end else if (scl_fall) begin
                     if (cnt == 4'h8) begin
                        state    <= led_pair_pkg::ST_RACK;
                        sda_oe_n <= 1'b1;
                     end else begin
                        shift    <= {shift[6:0], 1'b0};
                        sda_oe_n <= shift[6];
                     end
                  end
               end
               led_pair_pkg::ST_RACK: begin
                  if (scl_rise) begin
                     if (sda) begin
                        state <= led_pair_pkg::ST_IDLE;
                     end else begin
                        state     <= led_pair_pkg::ST_ACK;
                        after     <= led_pair_pkg::ST_RDATA;
                        reg_index <= reg_index + 2'h1;
                     end
                  end
               end
               default: begin
                  state <= led_pair_pkg::ST_IDLE;
               end
            endcase
         end
      end
   end

   // ==========================================================================
   // Checks
   foreign_addr_a: assert property (@(posedge clock) disable iff (rst)
      (state == led_pair_pkg::ST_DEVADDR && scl_fall && cnt == 4'h8 && !clear && !stop_seen && !start_seen
       && shift[7:1] != led_pair_pkg::BUS_ADDRESS) |=> sda_oe_n && state == led_pair_pkg::ST_IDLE)
      else $error("Target answered a foreign address.");

   read_nack_a: assert property (@(posedge clock) disable iff (rst)
      (state == led_pair_pkg::ST_RACK && scl_rise && sda && !clear && !stop_seen && !start_seen)
      |=> state == led_pair_pkg::ST_IDLE ##1 sda_oe_n)
      else $error("Read did not end after a refused byte.");

   read_cover: cover property (@(posedge clock) disable iff (rst)
      state == led_pair_pkg::ST_RACK && scl_rise && sda);

endmodule

// *** logic/led_pair_current_control.sv ***
// Control logic of the six-channel LED driver: registers, channel gating and pump mode choice.
`timescale 1ns/1ps

// How it works
// - Undervoltage forces every channel off whatever the registers hold.
// - On enable rising every channel starts at zero current.
// - Enable low holds shutdown with every cathode output high impedance.
// - Pump starts in 1x and stays there while regulation holds.
// - Lost regulation moves the pump to 1.5x after 400 microseconds.
// - Mode choice restarts at reset, on leaving shutdown and on on/off writes.
// - Four 8-bit registers are writable and readable over the serial bus.
// - Addresses 0, 1, 2 hold pair A, B, C current codes; bits 7:6 unused.
// - Address 3 holds one on bit per channel, A1 at bit 0 to C2 at bit 5.
// - Code n gives (n+1) times 0.5 mA, 0.5 to 32 mA.
// - Only bus address 1100110 is answered.
// - A read is address write, repeated start, then bytes from successive registers until the host refuses one.
module led_pair_current_control #(
   parameter int unsigned MODE_DELAY_CYCLES = led_pair_pkg::MODE_DELAY_CYCLES
) (
   // Clock and reset
   input  wire logic       CLOCK,
   input  wire logic       RST,
   // Analogue status and enable
   input  wire logic       ENABLE,
   input  wire logic       UNDERVOLTAGE,
   input  wire logic       REGULATION_OK,
   // Serial bus
   input  wire logic       SCL,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_N,
   // Channel drive, current in 0.5 mA steps, zero when off
   output logic [6:0]      CHANNEL_A_FIRST,
   output logic [6:0]      CHANNEL_A_SECOND,
   output logic [6:0]      CHANNEL_B_FIRST,
   output logic [6:0]      CHANNEL_B_SECOND,
   output logic [6:0]      CHANNEL_C_FIRST,
   output logic [6:0]      CHANNEL_C_SECOND,
   output logic [5:0]      SINK_ON,
   output logic            CATHODE_HIZ,
   // Charge pump
   output logic            PUMP_HALF
);

   logic [5:0]               regs [4];
   logic [1:0]               reg_index;
   logic                     wr_stb;
   logic [1:0]               wr_addr;
   logic [7:0]               wr_data;
   logic [16:0]              wait_cnt;
   led_pair_pkg::pump_mode_t mode;

   wire [5:0] pair_a     = regs[led_pair_pkg::PAIR_A_OFFSET];
   wire [5:0] pair_b     = regs[led_pair_pkg::PAIR_B_OFFSET];
   wire [5:0] pair_c     = regs[led_pair_pkg::PAIR_C_OFFSET];
   wire [5:0] on_off     = regs[led_pair_pkg::ON_OFF_OFFSET];
   wire       drive_ok   = ENABLE && !UNDERVOLTAGE;
   wire       on_off_wr  = ENABLE && wr_stb && wr_addr == led_pair_pkg::ON_OFF_OFFSET;
   wire       restart    = !ENABLE || on_off_wr;
   wire [16:0] wait_last = 17'(MODE_DELAY_CYCLES - 1);

   // Current level of one channel in half-milliamp units, zero when not driven.
   function automatic logic [6:0] level(input logic [5:0] code, input logic on);
      level = on ? ({1'b0, code} + 7'h01) : 7'h00;
   endfunction

   // ==========================================================================
   // Bus target
   // The target is held idle in shutdown so that a half-finished transfer cannot land later.
   serial_register_port port (
      .clock     (CLOCK),
      .rst       (RST),
      .clear     (!ENABLE),
      .scl       (SCL),
      .sda       (SDA_IN),
      .sda_oe_n  (SDA_OE_N),
      .rd_data   ({2'b00, regs[reg_index]}),
      .reg_index (reg_index),
      .wr_stb    (wr_stb),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data)
   );

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         SDA_OUT <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
      end
   end

   // ==========================================================================
   // Register file
   // Only the six used bits are kept; the upper two always read back as zero.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i < 4; i++) begin
            regs[i] <= led_pair_pkg::REG_RESET;
         end
      end else if (!ENABLE) begin
         for (int i = 0; i < 4; i++) begin
            regs[i] <= led_pair_pkg::REG_RESET;
         end
      end else if (wr_stb) begin
         regs[wr_addr] <= wr_data[led_pair_pkg::CODE_MSB:0];
      end
   end

   // ==========================================================================
   // Pump mode choice
   // The 1.5x mode is sticky until a restart event, matching a pump that never steps back alone.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         mode     <= led_pair_pkg::MODE_1X;
         wait_cnt <= 17'h00000;
      end else if (restart) begin
         mode     <= led_pair_pkg::MODE_1X;
         wait_cnt <= 17'h00000;
      end else begin
         unique case (mode)
            led_pair_pkg::MODE_1X: begin
               wait_cnt <= 17'h00000;
               if (!REGULATION_OK) begin
                  mode <= led_pair_pkg::MODE_WAIT;
               end
            end
            led_pair_pkg::MODE_WAIT: begin
               if (REGULATION_OK) begin
                  mode <= led_pair_pkg::MODE_1X;
               end else if (wait_cnt == wait_last) begin
                  mode <= led_pair_pkg::MODE_1P5;
               end else begin
                  wait_cnt <= wait_cnt + 17'h00001;
               end
            end
            led_pair_pkg::MODE_1P5: begin
            end
            default: begin
               mode <= led_pair_pkg::MODE_1X;
            end
         endcase
      end
   end

   // ==========================================================================
   // Output stage
   // Outputs are registered, so channel changes lag their cause by one clock.
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         SINK_ON          <= 6'h00;
         CATHODE_HIZ      <= 1'b1;
         PUMP_HALF        <= 1'b0;
         CHANNEL_A_FIRST  <= 7'h00;
         CHANNEL_A_SECOND <= 7'h00;
         CHANNEL_B_FIRST  <= 7'h00;
         CHANNEL_B_SECOND <= 7'h00;
         CHANNEL_C_FIRST  <= 7'h00;
         CHANNEL_C_SECOND <= 7'h00;
      end else begin
         SINK_ON          <= drive_ok ? on_off : 6'h00;
         CATHODE_HIZ      <= !ENABLE;
         PUMP_HALF        <= mode == led_pair_pkg::MODE_1P5;
         CHANNEL_A_FIRST  <= level(pair_a, drive_ok && on_off[led_pair_pkg::CH_A_FIRST_BIT]);
         CHANNEL_A_SECOND <= level(pair_a, drive_ok && on_off[led_pair_pkg::CH_A_SECOND_BIT]);
         CHANNEL_B_FIRST  <= level(pair_b, drive_ok && on_off[led_pair_pkg::CH_B_FIRST_BIT]);
         CHANNEL_B_SECOND <= level(pair_b, drive_ok && on_off[led_pair_pkg::CH_B_SECOND_BIT]);
         CHANNEL_C_FIRST  <= level(pair_c, drive_ok && on_off[led_pair_pkg::CH_C_FIRST_BIT]);
         CHANNEL_C_SECOND <= level(pair_c, drive_ok && on_off[led_pair_pkg::CH_C_SECOND_BIT]);
      end
   end

   // ==========================================================================
   // Checks
   default clocking chk @(posedge CLOCK); endclocking
   default disable iff (RST);

   uv_forces_off_a: assert property (UNDERVOLTAGE |=> SINK_ON == 6'h00 && CHANNEL_C_SECOND == 7'h00)
      else $error("A channel sinks during undervoltage.");

   enable_starts_zero_a: assert property ($rose(ENABLE) |=> SINK_ON == 6'h00 ##1 on_off == 6'h00 || $past(wr_stb))
      else $error("A channel conducts right after enable.");

   shutdown_hiz_a: assert property (!ENABLE |=> CATHODE_HIZ && SINK_ON == 6'h00)
      else $error("Cathodes not high impedance in shutdown.");

   stay_in_1x_a: assert property (mode == led_pair_pkg::MODE_1X && REGULATION_OK |=> ##1 !PUMP_HALF)
      else $error("Pump left 1x while regulation held.");

   timed_switch_a: assert property (mode == led_pair_pkg::MODE_WAIT && !REGULATION_OK && !restart
      |=> (mode == led_pair_pkg::MODE_1P5) == ($past(wait_cnt) == wait_last))
      else $error("Pump moved to 1.5x at the wrong count.");

   write_restarts_a: assert property (on_off_wr |=> mode == led_pair_pkg::MODE_1X ##1 !PUMP_HALF)
      else $error("On/off write did not restart the mode choice.");

   reg_store_a: assert property (ENABLE && wr_stb ##1 ENABLE |-> regs[$past(wr_addr)] == $past(wr_data[5:0]))
      else $error("Register did not take the written byte.");

   level_code_a: assert property (drive_ok && on_off[0] |=> CHANNEL_A_FIRST == 7'($past(pair_a)) + 7'h01)
      else $error("Channel current does not match its code.");

   regs_cleared_a: assert property (!ENABLE |=> pair_a == 6'h00 && pair_c == 6'h00 && on_off == 6'h00)
      else $error("Registers not cleared in shutdown.");

   sink_gate_a: assert property (drive_ok |=> SINK_ON == $past(on_off))
      else $error("Sink state does not follow the on bits.");

   half_mode_cover: cover property (!REGULATION_OK && ENABLE ##1 PUMP_HALF);
   on_off_write_cover: cover property (on_off_wr ##1 on_off != 6'h00);
   uv_cover: cover property (SINK_ON != 6'h00 ##1 UNDERVOLTAGE);

endmodule

// *** sim/serial_host_model.sv ***
// Behavioural two-wire serial bus host that writes and reads the controller's registers.
`timescale 1ns/1ps

module serial_host_model #(
   parameter int Q = 8
) (
   // Clock
   input  wire logic clock,
   // Bus pins
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   // ==========================================================================
   // Bus phases
   // Released lines float high through the pull-up, so the idle state is scl high, sda released.
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic wait_q();
      repeat (Q) @(posedge clock);
   endtask

   // Also serves as the repeated start, since it first releases sda while scl is low.
   task automatic start();
      @(posedge clock);
      sda_low <= 1'b0;
      wait_q();
      scl <= 1'b1;
      wait_q();
      sda_low <= 1'b1;
      wait_q();
      scl <= 1'b0;
      wait_q();
   endtask

   task automatic stop();
      sda_low <= 1'b1;
      wait_q();
      scl <= 1'b1;
      wait_q();
      sda_low <= 1'b0;
      wait_q();
   endtask

   // Data is held for a whole third of the bit, Q clocks, after scl falls, well past the target's sampling lag.
   task automatic bit_xfer(input logic tx, output logic rx);
      sda_low <= !tx;
      wait_q();
      scl <= 1'b1;
      wait_q();
      rx = sda;
      scl <= 1'b0;
      wait_q();
   endtask

   task automatic byte_xfer(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx, output logic acked);
      logic a;
      for (int i = 7; i >= 0; i--) bit_xfer(tx[i], rx[i]);
      bit_xfer(ack_tx, a);
      acked = !a;
   endtask

   // ==========================================================================
   // Register transfers
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] addr, input logic [7:0] data,
                            output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      a1 = 1'b0;
      a2 = 1'b0;
      start();
      byte_xfer({dev, 1'b0}, 1'b1, rx, a0);
      if (a0) begin
         byte_xfer(addr, 1'b1, rx, a1);
         byte_xfer(data, 1'b1, rx, a2);
      end
      stop();
      ok = a0 & a1 & a2;
   endtask

   // Two data bytes in one transfer, so the second lands in the next register.
   task automatic write_pair(input logic [7:0] addr, input logic [7:0] d0, input logic [7:0] d1,
                             output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      start();
      byte_xfer({led_pair_pkg::BUS_ADDRESS, 1'b0}, 1'b1, rx, a0);
      byte_xfer(addr, 1'b1, rx, a1);
      byte_xfer(d0, 1'b1, rx, a2);
      byte_xfer(d1, 1'b1, rx, a3);
      stop();
      ok = a0 & a1 & a2 & a3;
   endtask

   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
      logic [7:0] rx;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       a3;
      start();
      byte_xfer({led_pair_pkg::BUS_ADDRESS, 1'b0}, 1'b1, rx, a0);
      byte_xfer(addr, 1'b1, rx, a1);
      start();
      byte_xfer({led_pair_pkg::BUS_ADDRESS, 1'b1}, 1'b1, rx, a2);
      byte_xfer(8'hFF, 1'b1, data, a3);
      stop();
      ok = a0 & a1 & a2 & !a3;
   endtask
endmodule

// *** sim/test_led_pair_current_control.sv ***
// Self-checking testbench of the LED pair current controller.
`timescale 1ns/1ps

module test_led_pair_current_control;
   // ==========================================================================
   // Signals
   localparam int unsigned DELAY = 20;
   logic       clock;
   logic       rst;
   logic       enable;
   logic       undervoltage;
   logic       regulation_ok;
   logic       scl;
   logic       host_low;
   logic       sda;
   logic       sda_out;
   logic       sda_oe_n;
   logic [6:0] ch_a1, ch_a2, ch_b1, ch_b2, ch_c1, ch_c2;
   logic [5:0] sink_on;
   logic       cathode_hiz;
   logic       pump_half;
   logic       ok;
   int         errors;
   int         compares;

   // The target only ever pulls low; a released wire reads high through the pull-up.
   assign sda = sda_oe_n & !host_low;

   led_pair_current_control #(.MODE_DELAY_CYCLES(DELAY)) u_dut (
      .CLOCK(clock), .RST(rst), .ENABLE(enable), .UNDERVOLTAGE(undervoltage),
      .REGULATION_OK(regulation_ok), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
      .SDA_OE_N(sda_oe_n), .CHANNEL_A_FIRST(ch_a1), .CHANNEL_A_SECOND(ch_a2),
      .CHANNEL_B_FIRST(ch_b1), .CHANNEL_B_SECOND(ch_b2), .CHANNEL_C_FIRST(ch_c1),
      .CHANNEL_C_SECOND(ch_c2), .SINK_ON(sink_on), .CATHODE_HIZ(cathode_hiz), .PUMP_HALF(pump_half));

   serial_host_model u_host (.clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));

   // ==========================================================================
   // Shared tasks
   task automatic end_of_test();
      if (errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t value %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      u_host.write_reg(led_pair_pkg::BUS_ADDRESS, addr, data, ok);
      check({7'h00, ok}, 8'h01);
   endtask

   task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      u_host.read_reg(addr, d, ok);
      check({7'h00, ok}, 8'h01);
      check(d, exp);
   endtask

   task automatic check_chans(input logic [5:0] a, input logic [5:0] b, input logic [5:0] c,
                              input logic [5:0] on);
      settle(3);
      check({1'b0, ch_a1}, on[0] ? {2'b00, a} + 8'h01 : 8'h00);
      check({1'b0, ch_a2}, on[1] ? {2'b00, a} + 8'h01 : 8'h00);
      check({1'b0, ch_b1}, on[2] ? {2'b00, b} + 8'h01 : 8'h00);
      check({1'b0, ch_b2}, on[3] ? {2'b00, b} + 8'h01 : 8'h00);
      check({1'b0, ch_c1}, on[4] ? {2'b00, c} + 8'h01 : 8'h00);
      check({1'b0, ch_c2}, on[5] ? {2'b00, c} + 8'h01 : 8'h00);
      check({2'b00, sink_on}, {2'b00, on});
   endtask

   // ==========================================================================
   // Scenarios
   task automatic test_reset_state();
      settle(1);
      check({7'h00, pump_half}, 8'h00);
      check({7'h00, cathode_hiz}, 8'h00);
      check({7'h00, sda_out}, 8'h00);
      check_chans(6'h00, 6'h00, 6'h00, 6'h00);
      for (int i = 0; i < 4; i++) rd_check(8'(i), 8'h00);
   endtask

   task automatic test_registers();
      wr(8'h00, 8'hC0);
      wr(8'h01, 8'hFF);
      wr(8'h02, 8'h15);
      wr(8'h03, 8'hFF);
      rd_check(8'h00, 8'h00);
      rd_check(8'h01, 8'h3F);
      rd_check(8'h02, 8'h15);
      rd_check(8'h03, 8'h3F);
      check_chans(6'h00, 6'h3F, 6'h15, 6'h3F);
      for (int i = 0; i < 6; i++) begin
         wr(8'h03, 8'h01 << i);
         check_chans(6'h00, 6'h3F, 6'h15, 6'h01 << i);
      end
      wr(8'h03, 8'h3F);
   endtask

   task automatic test_foreign();
      u_host.write_reg(7'h67, 8'h00, 8'h2A, ok);
      check({7'h00, ok}, 8'h00);
      rd_check(8'h00, 8'h00);
   endtask

   task automatic test_undervoltage();
      undervoltage <= 1'b1;
      check_chans(6'h00, 6'h3F, 6'h15, 6'h00);
      @(posedge clock);
      undervoltage <= 1'b0;
      check_chans(6'h00, 6'h3F, 6'h15, 6'h3F);
   endtask

   task automatic test_pump();
      @(posedge clock);
      regulation_ok <= 1'b0;
      settle(DELAY / 2);
      @(posedge clock);
      regulation_ok <= 1'b1;
      settle(2);
      @(posedge clock);
      regulation_ok <= 1'b0;
      settle(DELAY - 2);
      check({7'h00, pump_half}, 8'h00);
      settle(8);
      check({7'h00, pump_half}, 8'h01);
      @(posedge clock);
      regulation_ok <= 1'b1;
      wr(8'h03, 8'h3F);
      check({7'h00, pump_half}, 8'h00);
      regulation_ok <= 1'b0;
      settle(DELAY + 8);
      check({7'h00, pump_half}, 8'h01);
   endtask

   task automatic test_shutdown();
      @(posedge clock);
      enable <= 1'b0;
      check_chans(6'h00, 6'h3F, 6'h15, 6'h00);
      check({7'h00, cathode_hiz}, 8'h01);
      u_host.write_reg(led_pair_pkg::BUS_ADDRESS, 8'h03, 8'h3F, ok);
      check({7'h00, ok}, 8'h00);
      regulation_ok <= 1'b1;
      enable <= 1'b1;
      settle(3);
      check({7'h00, cathode_hiz}, 8'h00);
      check({7'h00, pump_half}, 8'h00);
      check_chans(6'h00, 6'h00, 6'h00, 6'h00);
      rd_check(8'h01, 8'h00);
      rd_check(8'h03, 8'h00);
   endtask

   // The register index wraps after the on/off register, so the second byte lands at address 0.
   task automatic test_auto_increment();
      u_host.write_pair(8'h03, 8'h3F, 8'h2B, ok);
      check({7'h00, ok}, 8'h01);
      rd_check(8'h03, 8'h3F);
      rd_check(8'h00, 8'h2B);
   endtask

   // ==========================================================================
   // Clock, reset, sequence and watchdog
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   initial begin
      errors = 0;
      compares = 0;
      rst = 1'b1;
      enable = 1'b1;
      undervoltage = 1'b0;
      regulation_ok = 1'b1;
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      test_reset_state();
      test_registers();
      test_foreign();
      test_undervoltage();
      test_pump();
      test_shutdown();
      test_auto_increment();
      end_of_test();
   end

   // The whole run takes about 22000 cycles, so well over twice that means a hang.
   initial begin
      repeat (60000) @(posedge clock);
      errors++;
      end_of_test();
   end
endmodule
